// file: flpw_defines.vh
// Shared constants of the four-level page walker: entry fields, control bits and
// the field geometry of a linear address.
// Assumes it is included by its bare name from every file of the walker.
`ifndef FLPW_DEFINES_VH
`define FLPW_DEFINES_VH

// ==========================================================================
// Control register fields
// ==========================================================================
// Long-mode-active flag in the extended feature enable register.
`define FLPW_FEAT_LONG_MODE_BIT 10
// No-execute enable flag in the extended feature enable register.
`define FLPW_EFER_NXE_BIT 11

// ==========================================================================
// Paging-structure entry fields
// ==========================================================================
`define FLPW_ENT_PRESENT 0
`define FLPW_ENT_WRITE 1
`define FLPW_ENT_USER 2
`define FLPW_ENT_PWT 3
`define FLPW_ENT_PCD 4
`define FLPW_ENT_NX 63
// Table bases and frame bases are aligned on this many low bits.
`define FLPW_BASE_LSB 12

// ==========================================================================
// Linear address geometry
// ==========================================================================
// Width of the index into one table level.
`define FLPW_IDX_W 9
// Width of the offset within a page frame.
`define FLPW_OFS_W 12
// Byte size of one entry, as a shift.
`define FLPW_ENT_SHIFT 3
// Number of table levels in a long-mode walk, and the code of the last level.
`define FLPW_LEVELS 4
`define FLPW_LAST_LEVEL 2'h3
`define FLPW_FIRST_LEVEL 2'h0

// ==========================================================================
// Reset values
// ==========================================================================
`define FLPW_RIGHTS_RESET 3'h0
`define FLPW_CACHE_RESET 2'h0

`endif

// file: flpw_index.v
// Address splitter of the page walker: picks the table index for one level and
// forms the physical address of the entry to fetch.
// Assumes the table base is aligned and the level code is 0 for the top-level map.
`timescale 1ns/10ps
`include "flpw_defines.vh"

module flpw_index #(
	parameter LIN_W = 48,
	parameter PA_W = 52
) (
	input wire [LIN_W-1:0] linear,
	input wire [1:0] level,
	input wire [PA_W-1:0] table_base,
	output wire [PA_W-1:0] entry_addr,
	output wire [`FLPW_OFS_W-1:0] page_offset
);

	// ==========================================================================
	// Field extraction
	// ==========================================================================
	wire [`FLPW_IDX_W*`FLPW_LEVELS-1:0] fields;
	reg [`FLPW_IDX_W-1:0] index_sel;

	// Split into level fields.
	// Level g takes the field that lies g levels below the top of the address.
	genvar g;
	generate
		for (g = 0; g < `FLPW_LEVELS; g = g + 1)
		begin : g_field
			assign fields[g*`FLPW_IDX_W +: `FLPW_IDX_W] =
				linear[`FLPW_OFS_W + (`FLPW_LEVELS-1-g)*`FLPW_IDX_W +: `FLPW_IDX_W];
		end
	endgenerate

	// Select the field of the level being visited.
	always @*
	begin
		index_sel = fields[level*`FLPW_IDX_W +: `FLPW_IDX_W];
	end

	// Base from previous level.
	// The entry sits at the table base plus index times entry size.
	assign entry_addr = {table_base[PA_W-1:`FLPW_BASE_LSB], index_sel,
		{`FLPW_ENT_SHIFT{1'b0}}};
	assign page_offset = linear[`FLPW_OFS_W-1:0];

endmodule // flpw_index

// file: flpw_rights.v
// Entry decoder of the page walker: checks one fetched entry against the access
// and extracts its base address and attributes.
// Assumes the access flags stay steady while the entry is presented.
`timescale 1ns/10ps
`include "flpw_defines.vh"

module flpw_rights #(
	parameter PA_W = 52
) (
	input wire [63:0] entry,
	input wire acc_write,
	input wire acc_user,
	input wire acc_fetch,
	input wire nx_enable,
	output wire deny,
	output wire not_present,
	output wire [PA_W-1:0] next_base,
	output wire ent_write,
	output wire ent_user,
	output wire ent_exec,
	output wire [1:0] ent_cache
);

	// ==========================================================================
	// Entry decode
	// ==========================================================================
	// Extract base and attributes.
	assign next_base = {entry[PA_W-1:`FLPW_BASE_LSB], {`FLPW_BASE_LSB{1'b0}}};
	assign ent_write = entry[`FLPW_ENT_WRITE];
	assign ent_user = entry[`FLPW_ENT_USER];
	// The no-execute bit only counts once software has enabled it.
	assign ent_exec = ~(nx_enable & entry[`FLPW_ENT_NX]);
	assign ent_cache = {entry[`FLPW_ENT_PCD], entry[`FLPW_ENT_PWT]};
	assign not_present = ~entry[`FLPW_ENT_PRESENT];

	// Deny on rights mismatch.
	// Any single missing right on any level denies the whole access.
	assign deny = not_present | (acc_write & ~ent_write) | (acc_user & ~ent_user) |
		(acc_fetch & ~ent_exec);

endmodule // flpw_rights

// file: flpw_walker.v
// Linear-to-physical translator with a four-level table walk over a memory port.
// Assumes control inputs, requests and memory answers come from logic on clock;
// memory answers only after a taken fetch, one answer per fetch, in order.
`timescale 1ns/10ps
`include "flpw_defines.vh"

module flpw_walker #(
	parameter LIN_W = 48,
	parameter PA_W = 52
) (
	input wire clock,
	input wire rst_n,
	input wire paging_enable,
	input wire [63:0] paging_base_control,
	input wire [63:0] extended_feature_enable,
	input wire req_valid,
	output wire req_ready,
	input wire [LIN_W-1:0] req_linear,
	input wire req_write,
	input wire req_user,
	input wire req_fetch,
	input wire req_system,
	output wire mem_req_valid,
	input wire mem_req_ready,
	output wire [PA_W-1:0] mem_req_addr,
	input wire mem_rsp_valid,
	input wire [63:0] mem_rsp_data,
	output wire rsp_valid,
	output wire [PA_W-1:0] rsp_phys,
	output wire rsp_fault,
	output wire rsp_not_present,
	output wire rsp_mode_fault,
	output wire [1:0] rsp_fault_level,
	output wire [2:0] rsp_rights,
	output wire [1:0] rsp_cache,
	output wire rsp_system
);

	// ==========================================================================
	// States
	// ==========================================================================
	localparam ST_IDLE = 3'h0;
	localparam ST_ADDR = 3'h1;
	localparam ST_FETCH = 3'h2;
	localparam ST_WAIT = 3'h3;
	localparam ST_RESP = 3'h4;

	// ==========================================================================
	// Declarations
	// ==========================================================================
	reg [2:0] state_reg, state_next;
	reg [1:0] level_reg, level_next;
	reg [PA_W-1:0] table_base_reg, table_base_next;
	reg [LIN_W-1:0] linear_reg, linear_next;
	reg write_reg, write_next;
	reg user_reg, user_next;
	reg fetch_reg, fetch_next;
	reg nxe_reg, nxe_next;
	reg [PA_W-1:0] addr_reg, addr_next;
	reg acc_rw_reg, acc_rw_next;
	reg acc_us_reg, acc_us_next;
	reg acc_x_reg, acc_x_next;
	reg [PA_W-1:0] phys_reg, phys_next;
	reg fault_reg, fault_next;
	reg not_present_reg, not_present_next;
	reg mode_fault_reg, mode_fault_next;
	reg [1:0] fault_level_reg, fault_level_next;
	reg [1:0] cache_reg, cache_next;
	reg system_reg, system_next;
	wire walk_mode;
	wire [PA_W-1:0] idx_entry_addr;
	wire [`FLPW_OFS_W-1:0] idx_offset;
	wire ent_deny;
	wire ent_not_present;
	wire [PA_W-1:0] ent_base;
	wire ent_write;
	wire ent_user;
	wire ent_exec;
	wire [1:0] ent_cache;

	// ==========================================================================
	// Mode selection
	// ==========================================================================
	// Long-mode-active gates walk.
	// Only paging with long mode active walks the four-level hierarchy.
	assign walk_mode = paging_enable & extended_feature_enable[`FLPW_FEAT_LONG_MODE_BIT];

	// ==========================================================================
	// Address splitting and entry decode
	// ==========================================================================
	// The index unit works on the captured address and the current level base.
	flpw_index #(
		.LIN_W(LIN_W),
		.PA_W(PA_W)
	) u_index (
		.linear(linear_reg),
		.level(level_reg),
		.table_base(table_base_reg),
		.entry_addr(idx_entry_addr),
		.page_offset(idx_offset)
	);

	// The decoder looks at the memory answer directly, so a verdict is ready
	// in the very cycle the entry arrives and no extra stage is spent.
	flpw_rights #(
		.PA_W(PA_W)
	) u_rights (
		.entry(mem_rsp_data),
		.acc_write(write_reg),
		.acc_user(user_reg),
		.acc_fetch(fetch_reg),
		.nx_enable(nxe_reg),
		.deny(ent_deny),
		.not_present(ent_not_present),
		.next_base(ent_base),
		.ent_write(ent_write),
		.ent_user(ent_user),
		.ent_exec(ent_exec),
		.ent_cache(ent_cache)
	);

	// ==========================================================================
	// Next-state logic
	// ==========================================================================
	// Every register holds its value unless the state below says otherwise.
	always @*
	begin
		state_next = state_reg;
		level_next = level_reg;
		table_base_next = table_base_reg;
		linear_next = linear_reg;
		write_next = write_reg;
		user_next = user_reg;
		fetch_next = fetch_reg;
		nxe_next = nxe_reg;
		addr_next = addr_reg;
		acc_rw_next = acc_rw_reg;
		acc_us_next = acc_us_reg;
		acc_x_next = acc_x_reg;
		phys_next = phys_reg;
		fault_next = fault_reg;
		not_present_next = not_present_reg;
		mode_fault_next = mode_fault_reg;
		fault_level_next = fault_level_reg;
		cache_next = cache_reg;
		system_next = system_reg;
		case (state_reg)
			ST_IDLE:
			begin
				if (req_valid)
				begin
					linear_next = req_linear;
					write_next = req_write;
					user_next = req_user;
					fetch_next = req_fetch;
					// System accesses walk alike.
					// Descriptor-table reads take the same path as any other access.
					system_next = req_system;
					nxe_next = extended_feature_enable[`FLPW_EFER_NXE_BIT];
					// Hierarchy per base value.
					// The base is sampled per request, so a new value takes effect
					// on the next request and never in the middle of a walk.
					table_base_next = {paging_base_control[PA_W-1:`FLPW_BASE_LSB],
						{`FLPW_BASE_LSB{1'b0}}};
					level_next = `FLPW_FIRST_LEVEL;
					acc_rw_next = 1'b1;
					acc_us_next = 1'b1;
					acc_x_next = 1'b1;
					fault_next = 1'b0;
					not_present_next = 1'b0;
					mode_fault_next = 1'b0;
					fault_level_next = `FLPW_FIRST_LEVEL;
					cache_next = `FLPW_CACHE_RESET;
					if (walk_mode)
					begin
						state_next = ST_ADDR;
					end
					else if (paging_enable)
					begin
						// Paging without long mode has no walk here; refuse it.
						fault_next = 1'b1;
						mode_fault_next = 1'b1;
						phys_next = {PA_W{1'b0}};
						state_next = ST_RESP;
					end
					else
					begin
						phys_next = {{(PA_W-LIN_W){1'b0}}, req_linear};
						state_next = ST_RESP;
					end
				end
			end
			ST_ADDR:
			begin
				addr_next = idx_entry_addr;
				state_next = ST_FETCH;
			end
			ST_FETCH:
			begin
				if (mem_req_ready)
				begin
					state_next = ST_WAIT;
				end
			end
			ST_WAIT:
			begin
				if (mem_rsp_valid)
				begin
					acc_rw_next = acc_rw_reg & ent_write;
					acc_us_next = acc_us_reg & ent_user;
					acc_x_next = acc_x_reg & ent_exec;
					cache_next = ent_cache;
					if (ent_deny)
					begin
						fault_next = 1'b1;
						not_present_next = ent_not_present;
						fault_level_next = level_reg;
						phys_next = {PA_W{1'b0}};
						state_next = ST_RESP;
					end
					else if (level_reg == `FLPW_LAST_LEVEL)
					begin
						phys_next = {ent_base[PA_W-1:`FLPW_OFS_W], idx_offset};
						state_next = ST_RESP;
					end
					else
					begin
						table_base_next = ent_base;
						level_next = level_reg + 2'h1;
						state_next = ST_ADDR;
					end
				end
			end
			ST_RESP:
			begin
				state_next = ST_IDLE;
			end
			default:
			begin
				state_next = ST_IDLE;
			end
		endcase
	end

	// ==========================================================================
	// State registers
	// ==========================================================================
	// Four-level walk registers.
	// The level counter is two bits wide, so a walk can never pass four levels.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= ST_IDLE;
			level_reg <= `FLPW_FIRST_LEVEL;
			table_base_reg <= {PA_W{1'b0}};
			linear_reg <= {LIN_W{1'b0}};
			write_reg <= 1'b0;
			user_reg <= 1'b0;
			fetch_reg <= 1'b0;
			nxe_reg <= 1'b0;
			addr_reg <= {PA_W{1'b0}};
			acc_rw_reg <= 1'b0;
			acc_us_reg <= 1'b0;
			acc_x_reg <= 1'b0;
			phys_reg <= {PA_W{1'b0}};
			fault_reg <= 1'b0;
			not_present_reg <= 1'b0;
			mode_fault_reg <= 1'b0;
			fault_level_reg <= `FLPW_FIRST_LEVEL;
			cache_reg <= `FLPW_CACHE_RESET;
			system_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			level_reg <= level_next;
			table_base_reg <= table_base_next;
			linear_reg <= linear_next;
			write_reg <= write_next;
			user_reg <= user_next;
			fetch_reg <= fetch_next;
			nxe_reg <= nxe_next;
			addr_reg <= addr_next;
			acc_rw_reg <= acc_rw_next;
			acc_us_reg <= acc_us_next;
			acc_x_reg <= acc_x_next;
			phys_reg <= phys_next;
			fault_reg <= fault_next;
			not_present_reg <= not_present_next;
			mode_fault_reg <= mode_fault_next;
			fault_level_reg <= fault_level_next;
			cache_reg <= cache_next;
			system_reg <= system_next;
		end
	end

	// ==========================================================================
	// Outputs
	// ==========================================================================
	// Handshakes decode the state; data comes straight from registers.
	assign req_ready = (state_reg == ST_IDLE);
	assign mem_req_valid = (state_reg == ST_FETCH);
	assign mem_req_addr = addr_reg;
	assign rsp_valid = (state_reg == ST_RESP);
	assign rsp_phys = phys_reg; // Zero whenever the answer is a fault.
	assign rsp_fault = fault_reg;
	assign rsp_not_present = not_present_reg;
	assign rsp_mode_fault = mode_fault_reg;
	assign rsp_fault_level = fault_level_reg;
	// Rights are write, user, execute as seen through all visited levels.
	assign rsp_rights = {acc_x_reg, acc_us_reg, acc_rw_reg};
	assign rsp_cache = cache_reg;
	assign rsp_system = system_reg;

	// The 64-bit base input holds addresses past 32 bits; the feature input holds only flags.

endmodule // flpw_walker

// file: flpw_walker_asserts.sv
// Port-level assertions of the four-level page walker.
// Assumes one clock domain and a memory that answers each fetch once.
`timescale 1ns/10ps
// ====================
// Checker
module flpw_walker_asserts #(
	parameter LIN_W = 48,
	parameter PA_W = 52
) (
	input wire clock,
	input wire rst_n,
	input wire paging_enable,
	input wire [63:0] paging_base_control,
	input wire [63:0] extended_feature_enable,
	input wire req_valid,
	input wire req_ready,
	input wire [LIN_W-1:0] req_linear,
	input wire mem_req_valid,
	input wire mem_req_ready,
	input wire [PA_W-1:0] mem_req_addr,
	input wire mem_rsp_valid,
	input wire [63:0] mem_rsp_data,
	input wire rsp_valid,
	input wire [PA_W-1:0] rsp_phys,
	input wire rsp_fault,
	input wire rsp_not_present,
	input wire rsp_mode_fault,
	input wire [1:0] rsp_fault_level
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	wire take = req_valid && req_ready;
	reg [2:0] fetch_reg;
	reg walk_reg;
	reg [LIN_W-1:0] lin_reg;
	reg [63:0] last_reg;
	// Fetches taken in this walk, and what its answer must be built from.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fetch_reg <= 3'h0;
			walk_reg <= 1'h0;
			lin_reg <= {LIN_W{1'h0}};
			last_reg <= 64'h0;
		end
		else
		begin
			fetch_reg <= take ? 3'h0 : fetch_reg + {2'h0, mem_req_valid && mem_req_ready};
			walk_reg <= take ? paging_enable && extended_feature_enable[10] : walk_reg;
			lin_reg <= take ? req_linear : lin_reg;
			last_reg <= mem_rsp_valid ? mem_rsp_data : last_reg;
		end
	end
	sequence walk_start;
		take && paging_enable && extended_feature_enable[10];
	endsequence
	// An entry with full rights and no no-execute bit lets the walk go on for any access.
	sequence entry_ok;
		mem_rsp_valid && walk_reg && fetch_reg < 3'h4 && mem_rsp_data[2:0] == 3'h7
			&& !mem_rsp_data[63];
	endsequence
	pass_through_a:
	assert property (take && !paging_enable |=> rsp_valid && !rsp_fault && !mem_req_valid
		&& rsp_phys == {{(PA_W-LIN_W){1'h0}}, $past(req_linear)}) else $error("passthrough wrong");
	mode_fault_a:
	assert property (take && paging_enable && !extended_feature_enable[10] |=> rsp_valid
		&& rsp_fault && rsp_mode_fault && !mem_req_valid) else $error("mode fault wrong");
	first_fetch_a:
	assert property (walk_start |-> ##2 mem_req_valid && mem_req_addr == {$past(
		paging_base_control[PA_W-1:12], 2), $past(req_linear[LIN_W-1 -: 9], 2), 3'h0})
		else $error("first fetch address wrong");
	fetch_hold_a:
	assert property (mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req_addr))
		else $error("fetch dropped or moved");
	chain_base_a:
	assert property (entry_ok |-> ##2 mem_req_valid
		&& mem_req_addr[PA_W-1:12] == $past(mem_rsp_data[PA_W-1:12], 2))
		else $error("next fetch not chained");
	four_level_a:
	assert property (rsp_valid && walk_reg && !rsp_fault |-> fetch_reg == 3'h4)
		else $error("walk not four levels");
	frame_addr_a:
	assert property (rsp_valid && walk_reg && !rsp_fault
		|-> rsp_phys == {last_reg[PA_W-1:12], lin_reg[11:0]}) else $error("frame address wrong");
	absent_entry_a:
	assert property (mem_rsp_valid && walk_reg && !mem_rsp_data[0] |=> rsp_valid && rsp_fault
		&& rsp_not_present && rsp_phys == {PA_W{1'h0}}
		&& {1'h0, rsp_fault_level} == fetch_reg - 3'h1) else $error("absent entry not faulted");
	one_answer_a:
	assert property (rsp_valid |-> !req_ready ##1 req_ready && !rsp_valid)
		else $error("answer not one cycle");
endmodule // flpw_walker_asserts

bind flpw_walker flpw_walker_asserts #(.LIN_W(LIN_W), .PA_W(PA_W)) chk_u (
	.clock(clock), .rst_n(rst_n), .paging_enable(paging_enable),
	.paging_base_control(paging_base_control), .extended_feature_enable(extended_feature_enable),
	.req_valid(req_valid), .req_ready(req_ready), .req_linear(req_linear),
	.mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
	.mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data), .rsp_valid(rsp_valid),
	.rsp_phys(rsp_phys), .rsp_fault(rsp_fault), .rsp_not_present(rsp_not_present),
	.rsp_mode_fault(rsp_mode_fault), .rsp_fault_level(rsp_fault_level)
);

// file: flpw_memory_model.sv
// Behavioural physical memory holding the paging tables.
// Assumes one fetch at a time; slow sets the wait before taking and before answering.
`timescale 1ns/10ps
// ====================
// Memory model
module flpw_memory_model (
	input wire clock,
	input wire rst_n,
	input wire [3:0] slow,
	input wire mem_req_valid,
	output wire mem_req_ready,
	input wire [51:0] mem_req_addr,
	output reg mem_rsp_valid,
	output reg [63:0] mem_rsp_data
);
	logic [63:0] mem [logic [51:0]];
	reg [3:0] wait_reg;
	reg pend_reg;
	reg [51:0] addr_reg;
	wire [51:0] at = mem_req_ready ? mem_req_addr : addr_reg;
	wire fire = mem_req_ready ? slow == 4'h0 : pend_reg && wait_reg >= slow;
	task put(input [51:0] a, input [63:0] d);
		mem[a] = d;
	endtask
	assign mem_req_ready = mem_req_valid && !pend_reg && wait_reg >= slow;
	// entries served from memory
	// Stale data is inverted every cycle so nothing can lean on a held value.
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wait_reg <= 4'h0;
			pend_reg <= 1'h0;
			addr_reg <= 52'h0;
			mem_rsp_valid <= 1'h0;
			mem_rsp_data <= 64'h0;
		end
		else
		begin
			mem_rsp_valid <= fire;
			mem_rsp_data <= fire ? (mem.exists(at) ? mem[at] : 64'h0) : ~mem_rsp_data;
			pend_reg <= mem_req_ready ? slow != 4'h0 : pend_reg && !fire;
			addr_reg <= at;
			wait_reg <= (mem_req_ready || fire || !(mem_req_valid || pend_reg))
				? {3'h0, mem_req_ready} : wait_reg + 4'h1;
		end
	end
endmodule // flpw_memory_model

// file: test_four_level_page_walker.sv
// Self-checking bench of the page walker with a behavioural table memory.
// Assumes the walker, its checker and the memory model are compiled first.
`timescale 1ns/10ps
// ====================
// Bench
module test_four_level_page_walker;
	reg clock = 1'h0;
	reg rst_n = 1'h0;
	reg paging_enable = 1'h0;
	reg [63:0] paging_base_control = 64'h0;
	reg [63:0] extended_feature_enable = 64'h0;
	reg req_valid = 1'h0;
	reg [47:0] req_linear = 48'h0;
	reg req_write = 1'h0;
	reg req_user = 1'h1;
	reg req_fetch = 1'h0;
	reg req_system = 1'h0;
	reg [3:0] slow = 4'h0;
	wire req_ready, mem_req_valid, mem_req_ready, mem_rsp_valid, rsp_valid, rsp_fault;
	wire rsp_not_present, rsp_mode_fault, rsp_system;
	wire [51:0] mem_req_addr, rsp_phys;
	wire [63:0] mem_rsp_data;
	wire [1:0] rsp_fault_level, rsp_cache;
	wire [2:0] rsp_rights;
	int bad_count = 0;
	int checked = 0;
	localparam [47:0] LIN = {9'h101, 9'h0a2, 9'h153, 9'h064, 12'hdef};
	// Half period of the 250 MHz clock.
	always #2 clock = ~clock;
	flpw_walker dut_u (.clock(clock), .rst_n(rst_n), .paging_enable(paging_enable),
		.paging_base_control(paging_base_control), .extended_feature_enable(extended_feature_enable),
		.req_valid(req_valid), .req_ready(req_ready), .req_linear(req_linear),
		.req_write(req_write), .req_user(req_user), .req_fetch(req_fetch),
		.req_system(req_system),
		.mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
		.mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data), .rsp_valid(rsp_valid),
		.rsp_phys(rsp_phys), .rsp_fault(rsp_fault), .rsp_not_present(rsp_not_present),
		.rsp_mode_fault(rsp_mode_fault), .rsp_fault_level(rsp_fault_level),
		.rsp_rights(rsp_rights), .rsp_cache(rsp_cache), .rsp_system(rsp_system));
	flpw_memory_model mem_u (.clock(clock), .rst_n(rst_n), .slow(slow),
		.mem_req_valid(mem_req_valid), .mem_req_ready(mem_req_ready), .mem_req_addr(mem_req_addr),
		.mem_rsp_valid(mem_rsp_valid), .mem_rsp_data(mem_rsp_data));
	task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task results();
		if (bad_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Lays out one chain of four tables; level lvl gets flags flg, the others full rights.
	task build(input [51:0] b, input [51:0] frame, input [1:0] lvl, input [63:0] flg);
		reg [51:0] tbl;
		reg [51:0] nxt;
		for (int l = 0; l < 4; l++)
		begin
			tbl = b + l * 52'h1000;
			nxt = (l == 3) ? frame : tbl + 52'h1000;
			mem_u.put(tbl + {LIN[12 + 9 * (3 - l) +: 9], 3'h0},
				(l == lvl) ? {flg[63:52], nxt[51:12], flg[11:0]} : {12'h0, nxt[51:12], 12'h007});
		end
	endtask
	// Holds the request until taken, then waits a bounded time for the answer.
	// The access kind acc is {no-execute enable, fetch, user, write}.
	task translate(input pg, input long_mode, input [63:0] base, input [3:0] acc, input sys);
		int n;
		paging_enable = pg;
		extended_feature_enable = {52'h0, acc[3], long_mode, 10'h0};
		paging_base_control = base;
		req_linear = LIN;
		req_write = acc[0];
		req_user = acc[1];
		req_fetch = acc[2];
		req_system = sys;
		req_valid = 1'h1;
		n = 0;
		while (req_ready !== 1'h1) @(negedge clock);
		@(negedge clock);
		req_valid = 1'h0;
		while (rsp_valid !== 1'h1 && n < 200)
		begin
			@(negedge clock);
			n++;
		end
		check("answer", rsp_valid, 1'h1);
	endtask
	task t_passthrough();
		translate(1'h0, 1'h0, 64'h0, 4'h3, 1'h0);
		check("phys", rsp_phys, {4'h0, LIN});
		check("fault", rsp_fault, 1'h0);
		check("rights", rsp_rights, 3'h7);
	endtask
	task t_mode();
		translate(1'h1, 1'h0, 64'h10000, 4'h3, 1'h0);
		check("fault", rsp_fault, 1'h1);
		check("mode", rsp_mode_fault, 1'h1);
	endtask
	task t_walk(input [51:0] b, input [51:0] frame, input [3:0] s, input sys);
		slow = s;
		translate(1'h1, 1'h1, {12'h0, b}, 4'h3, sys);
		check("phys", rsp_phys, {frame[51:12], LIN[11:0]});
		check("fault", rsp_fault, 1'h0);
		check("rights", rsp_rights, 3'h7);
		check("cache", rsp_cache, 2'h2);
		check("system", rsp_system, sys);
	endtask
	task t_fault(input [1:0] lvl, input [11:0] flg, input notp);
		build(52'h80000 + {lvl, 16'h0}, 52'h0, lvl, flg);
		translate(1'h1, 1'h1, 64'h80000 + {lvl, 16'h0}, 4'h3, 1'h0);
		check("fault", rsp_fault, 1'h1);
		check("absent", rsp_not_present, notp);
		check("level", rsp_fault_level, lvl);
		check("phys", rsp_phys, 52'h0);
	endtask
	// One access kind against one entry's flags; rights are folded even on a fault.
	task t_rights(input [1:0] lvl, input [63:0] flg, input [3:0] acc, input flt, input [2:0] rgt);
		build(52'hc0000 + {lvl, 16'h0}, 52'h3_3333_3000, lvl, flg);
		translate(1'h1, 1'h1, 64'hc0000 + {lvl, 16'h0}, acc, 1'h0);
		check("fault", rsp_fault, flt);
		check("level", rsp_fault_level, flt ? lvl : 2'h0);
		check("rights", rsp_rights, rgt);
		check("phys", rsp_phys, flt ? 52'h0 : {40'h33_3333, LIN[11:0]});
	endtask
	// Main sequence: two hierarchies side by side, then faults at two depths.
	initial
	begin
		repeat (6) @(negedge clock);
		rst_n = 1'h1;
		@(negedge clock);
		build(52'h10000, 52'h7_7777_7000, 2'h3, 12'h017);
		build(52'h20000, 52'h5_5555_5000, 2'h3, 12'h017);
		t_passthrough();
		t_mode();
		t_walk(52'h10000, 52'h7_7777_7000, 4'h0, 1'h0);
		t_walk(52'h20000, 52'h5_5555_5000, 4'h3, 1'h1);
		t_walk(52'h10000, 52'h7_7777_7000, 4'h1, 1'h0);
		t_fault(2'h2, 12'h006, 1'h1);
		t_fault(2'h1, 12'h005, 1'h0);
		// No-execute only denies a fetch once enabled; user access needs the user bit.
		t_rights(2'h3, 64'h8000_0000_0000_0007, 4'he, 1'h1, 3'h3);
		t_rights(2'h3, 64'h8000_0000_0000_0007, 4'h6, 1'h0, 3'h7);
		t_rights(2'h3, 64'h8000_0000_0000_0007, 4'ha, 1'h0, 3'h3);
		t_rights(2'h0, 64'h0000_0000_0000_0003, 4'h3, 1'h1, 3'h5);
		t_rights(2'h0, 64'h0000_0000_0000_0003, 4'h1, 1'h0, 3'h5);
		results();
	end
	// Watchdog: the whole run needs a little over two hundred cycles.
	initial
	begin
		repeat (5000) @(posedge clock);
		bad_count++;
		results();
	end
endmodule // test_four_level_page_walker
